// ### dsg_pkg.sv
`default_nettype none
package dsg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] SRC0_OFFSET = 12'h040;
  localparam logic [ADDR_W-1:0] RUN_RCC_OFFSET = 12'h060;
  localparam logic [ADDR_W-1:0] RCG2_OFFSET = 12'h108;
  localparam logic [ADDR_W-1:0] SCG2_OFFSET = 12'h118;
  localparam logic [ADDR_W-1:0] DCG2_OFFSET = 12'h128;
  localparam logic [ADDR_W-1:0] INT_STATUS_OFFSET = 12'h150;
  localparam logic [ADDR_W-1:0] INT_MASK_OFFSET = 12'h154;
  localparam logic [ADDR_W-1:0] MODE_STATUS_OFFSET = 12'h158;
  localparam logic [ADDR_W-1:0] FAULT_INFO_OFFSET = 12'h15c;
  // Gating register fields
  localparam int GATE_PORT_A_BIT = 0;
  localparam int GATE_PORT_B_BIT = 1;
  localparam int GATE_PORT_C_BIT = 2;
  localparam int GATE_PORT_D_BIT = 3;
  localparam int GATE_PORT_E_BIT = 4;
  localparam int GATE_MICRO_DMA_UNIT_BIT = 13;
  localparam logic [DATA_W-1:0] GATE_IMPL_MASK = 32'h0000201f;
  localparam logic [DATA_W-1:0] GATE_RESET = 32'h00000000;
  // Soft reset register fields
  localparam int SRC0_WDT_BIT = 3;
  localparam int SRC0_HIB_BIT = 6;
  localparam int SRC0_ADC_BIT = 16;
  localparam int SRC0_PWM_BIT = 20;
  localparam int SRC0_CAN_BIT = 24;
  localparam logic [DATA_W-1:0] SRC0_IMPL_MASK = 32'h01110048;
  localparam logic [DATA_W-1:0] SRC0_RESET = 32'h00000000;
  // Run clock config field
  localparam int AUTO_CLOCK_GATING_BIT = 27;
  localparam logic RCC_ACG_RESET = 1'b0;
  // Compact unit indexes
  localparam int NUM_GATED = 6;
  localparam int UNIT_MICRO_DMA_UNIT = 5;
  localparam int NUM_RESETS = 5;
  localparam int RST_WDT = 0;
  localparam int RST_HIB = 1;
  localparam int RST_ADC = 2;
  localparam int RST_PWM = 3;
  localparam int RST_CAN = 4;
  // Interrupt events
  localparam int EVT_FAULT = 0;
  localparam int EVT_MASKED = 1;
  localparam int EVT_MODE = 2;
  localparam int NUM_EVT = 3;
  localparam logic [NUM_EVT-1:0] INT_RESET = 3'h0;
  typedef enum logic [1:0] {DSG_RUN, DSG_SLEEP, DSG_DEEP} dsg_mode_t;
endpackage
`default_nettype wire

// ### dsg_clock_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dsg_clock_reset_ctrl
  import dsg_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DATA_W-1:0] device_capabilities_1,
  input wire logic sleep_entry,
  input wire logic deep_sleep_entry,
  input wire logic unit_access_valid,
  input wire logic [2:0] unit_access_id,
  output logic unit_access_fault,
  output logic [NUM_GATED-1:0] unit_clock_enable,
  output logic [NUM_RESETS-1:0] unit_reset,
  output logic irq
);

  logic rst_sync1;
  logic rst_n;
  logic [DATA_W-1:0] run_clock_gate_2;
  logic [DATA_W-1:0] sleep_clock_gate_2;
  logic [DATA_W-1:0] deep_sleep_clock_gate_2;
  logic [DATA_W-1:0] soft_reset_control_0;
  logic auto_clock_gating;
  logic [NUM_EVT-1:0] int_status;
  logic [NUM_EVT-1:0] int_mask;
  dsg_mode_t mode;
  dsg_mode_t next_mode;
  logic [NUM_GATED-1:0] gate_eff;
  logic [2:0] fault_id;
  logic fault_seen;
  logic setup_phase;
  logic xfer_done;
  logic wr_en;
  logic [NUM_EVT-1:0] evt;
  logic mode_changed;
  logic masked_write;
  logic access_denied;

  function automatic logic [NUM_GATED-1:0] gate_compact(input logic [DATA_W-1:0] r);
    gate_compact = {r[GATE_MICRO_DMA_UNIT_BIT], r[GATE_PORT_E_BIT], r[GATE_PORT_D_BIT],
                    r[GATE_PORT_C_BIT], r[GATE_PORT_B_BIT], r[GATE_PORT_A_BIT]};
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      SRC0_OFFSET, RUN_RCC_OFFSET, RCG2_OFFSET, SCG2_OFFSET, DCG2_OFFSET,
      INT_STATUS_OFFSET, INT_MASK_OFFSET, MODE_STATUS_OFFSET,
      FAULT_INFO_OFFSET: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  assign setup_phase = psel && !penable;
  assign xfer_done = psel && penable && pready;
  assign wr_en = xfer_done && pwrite && !pslverr;

  // APB slave: one wait-free access phase, answer prepared in setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= !addr_mapped(paddr);
    end else if (xfer_done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      case (paddr)
        SRC0_OFFSET: prdata <= soft_reset_control_0;
        RUN_RCC_OFFSET: prdata <= {4'h0, auto_clock_gating, 27'h0000000};
        RCG2_OFFSET: prdata <= run_clock_gate_2;
        SCG2_OFFSET: prdata <= sleep_clock_gate_2;
        DCG2_OFFSET: prdata <= deep_sleep_clock_gate_2;
        INT_STATUS_OFFSET: prdata <= {29'h00000000, int_status};
        INT_MASK_OFFSET: prdata <= {29'h00000000, int_mask};
        MODE_STATUS_OFFSET: prdata <= {22'h000000, gate_eff, 2'h0, mode};
        FAULT_INFO_OFFSET: prdata <= {27'h0000000, fault_seen, 1'b0, fault_id};
        default: prdata <= 32'h00000000;
      endcase
    end else if (xfer_done) begin
      prdata <= 32'h00000000;
    end
  end

  // Gating registers; reserved bits never stored so they read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_clock_gate_2 <= GATE_RESET;
      sleep_clock_gate_2 <= GATE_RESET;
      deep_sleep_clock_gate_2 <= GATE_RESET;
    end else if (wr_en) begin
      if (paddr == RCG2_OFFSET) begin
        run_clock_gate_2 <= pwdata & GATE_IMPL_MASK;
      end
      if (paddr == SCG2_OFFSET) begin
        sleep_clock_gate_2 <= pwdata & GATE_IMPL_MASK;
      end
      if (paddr == DCG2_OFFSET) begin
        deep_sleep_clock_gate_2 <= pwdata & GATE_IMPL_MASK;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      auto_clock_gating <= RCC_ACG_RESET;
    end else if (wr_en && paddr == RUN_RCC_OFFSET) begin
      auto_clock_gating <= pwdata[AUTO_CLOCK_GATING_BIT];
    end
  end

  // Absent units cannot be put into reset by software
  assign masked_write = wr_en && paddr == SRC0_OFFSET &&
                        |(pwdata & SRC0_IMPL_MASK & ~device_capabilities_1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_control_0 <= SRC0_RESET;
    end else if (wr_en && paddr == SRC0_OFFSET) begin
      soft_reset_control_0 <= pwdata & SRC0_IMPL_MASK & device_capabilities_1;
    end
  end

  // Power mode tracking; deep sleep outranks sleep
  always_comb begin
    next_mode = mode;
    case (mode)
      DSG_RUN: begin
        if (deep_sleep_entry) begin
          next_mode = DSG_DEEP;
        end else if (sleep_entry) begin
          next_mode = DSG_SLEEP;
        end
      end
      DSG_SLEEP: begin
        if (deep_sleep_entry) begin
          next_mode = DSG_DEEP;
        end else if (!sleep_entry) begin
          next_mode = DSG_RUN;
        end
      end
      DSG_DEEP: begin
        if (!deep_sleep_entry) begin
          next_mode = sleep_entry ? DSG_SLEEP : DSG_RUN;
        end
      end
      default: next_mode = DSG_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= DSG_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign mode_changed = next_mode != mode;

  // Without auto gating the run register stays in charge in every mode
  always_comb begin
    gate_eff = gate_compact(run_clock_gate_2);
    case (mode)
      DSG_RUN: gate_eff = gate_compact(run_clock_gate_2);
      DSG_SLEEP: begin
        if (auto_clock_gating) begin
          gate_eff = gate_compact(sleep_clock_gate_2);
        end
      end
      DSG_DEEP: begin
        if (auto_clock_gating) begin
          gate_eff = gate_compact(deep_sleep_clock_gate_2);
        end
      end
      default: gate_eff = gate_compact(run_clock_gate_2);
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unit_clock_enable <= '0;
    end else begin
      unit_clock_enable <= gate_eff;
    end
  end

  // Reset held as long as the control bit stays set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unit_reset <= '0;
    end else begin
      unit_reset[RST_WDT] <= soft_reset_control_0[SRC0_WDT_BIT];
      unit_reset[RST_HIB] <= soft_reset_control_0[SRC0_HIB_BIT];
      unit_reset[RST_ADC] <= soft_reset_control_0[SRC0_ADC_BIT];
      unit_reset[RST_PWM] <= soft_reset_control_0[SRC0_PWM_BIT];
      unit_reset[RST_CAN] <= soft_reset_control_0[SRC0_CAN_BIT];
    end
  end

  // Ids beyond the gated set are not ours to refuse
  assign access_denied = unit_access_valid && unit_access_id < 3'(NUM_GATED) &&
                         !gate_eff[unit_access_id];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unit_access_fault <= 1'b0;
    end else begin
      unit_access_fault <= access_denied;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_id <= 3'h0;
      fault_seen <= 1'b0;
    end else if (access_denied) begin
      fault_id <= unit_access_id;
      fault_seen <= 1'b1;
    end
  end

  assign evt[EVT_FAULT] = access_denied;
  assign evt[EVT_MASKED] = masked_write;
  assign evt[EVT_MODE] = mode_changed;

  // Set outranks a same-cycle write-one-to-clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= INT_RESET;
    end else if (wr_en && paddr == INT_STATUS_OFFSET) begin
      int_status <= (int_status & ~pwdata[NUM_EVT-1:0]) | evt;
    end else begin
      int_status <= int_status | evt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= INT_RESET;
    end else if (wr_en && paddr == INT_MASK_OFFSET) begin
      int_mask <= pwdata[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

endmodule // dsg_clock_reset_ctrl
`default_nettype wire

// ### dsg_clock_reset_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dsg_clock_reset_ctrl_monitor
  import dsg_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [DATA_W-1:0] device_capabilities_1,
  input wire logic sleep_entry,
  input wire logic deep_sleep_entry,
  input wire logic unit_access_valid,
  input wire logic [2:0] unit_access_id,
  input wire logic unit_access_fault,
  input wire logic [NUM_GATED-1:0] unit_clock_enable,
  input wire logic [NUM_RESETS-1:0] unit_reset
);
  logic acc;
  logic wr_src;
  logic wr_rcg;
  logic run_in;
  logic [31:0] mw;
  logic [4:0] rst_bits;
  logic [5:0] gate_bits;
  assign acc = psel && penable && pready;
  assign wr_src = acc && pwrite && !pslverr && paddr == SRC0_OFFSET;
  assign wr_rcg = acc && pwrite && !pslverr && paddr == RCG2_OFFSET;
  assign run_in = !sleep_entry && !deep_sleep_entry;
  assign mw = pwdata & device_capabilities_1;
  assign rst_bits = {mw[SRC0_CAN_BIT], mw[SRC0_PWM_BIT], mw[SRC0_ADC_BIT],
    mw[SRC0_HIB_BIT], mw[SRC0_WDT_BIT]};
  assign gate_bits = {pwdata[GATE_MICRO_DMA_UNIT_BIT], pwdata[4:0]};
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("unaligned access not refused");
  property p_zero; $rose(resetn) |-> (unit_clock_enable == 6'h00 && unit_reset == 5'h00) [*2];
  endproperty
  a_zero: assert property (p_zero) else $error("outputs not zero after reset");
  property p_fault; unit_access_fault == ($past(unit_access_valid) &&
    $past(unit_access_id) < 3'h6 && !unit_clock_enable[$past(unit_access_id)]); endproperty
  a_fault: assert property (p_fault) else $error("fault does not match gating");
  property p_run; run_in ##1 run_in && wr_rcg ##1 run_in |=>
    unit_clock_enable == $past(gate_bits, 2); endproperty
  a_run: assert property (p_run) else $error("run gate not applied");
  property p_srst; wr_src |-> ##2 unit_reset == $past(rst_bits, 2); endproperty
  a_srst: assert property (p_srst) else $error("reset write wrong");
  property p_hold; !$stable(unit_reset) |-> $past(wr_src, 2); endproperty
  a_hold: assert property (p_hold) else $error("reset moved unwritten");
  property p_dres; acc && !pwrite && paddr == DCG2_OFFSET |-> !(prdata & ~GATE_IMPL_MASK);
  endproperty
  a_dres: assert property (p_dres) else $error("gate reserved bits set");
  property p_sres; acc && !pwrite && paddr == SRC0_OFFSET |-> !(prdata & ~SRC0_IMPL_MASK);
  endproperty
  a_sres: assert property (p_sres) else $error("reset reserved bits set");
  c_fault: cover property (unit_access_fault);
  c_err: cover property (pready && pslverr);
  c_srst: cover property (unit_reset != 5'h00);
endmodule // dsg_clock_reset_ctrl_monitor
`default_nettype wire

// ### dsg_units.sv
`timescale 1ns/1ps
`default_nettype none
module dsg_units
  import dsg_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [2:0] go_id,
  input wire logic [NUM_GATED-1:0] unit_clock_enable,
  output logic unit_access_valid,
  output logic [2:0] unit_access_id,
  output logic [7:0] port_a_ticks
);
  initial begin
    unit_access_valid = 1'b0;
    unit_access_id = 3'h0;
    port_a_ticks = 8'h00;
  end
  // Idle id keeps toggling so a stale id is never mistaken for a request
  always @(posedge mclk) begin
    unit_access_valid <= go;
    unit_access_id <= go ? go_id : ~unit_access_id;
  end
  always @(posedge mclk) begin
    if (unit_clock_enable[GATE_PORT_A_BIT] === 1'b1) begin
      port_a_ticks <= port_a_ticks + 8'h01;
    end
  end
endmodule // dsg_units
`default_nettype wire

// ### dsg_clock_reset_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dsg_clock_reset_ctrl_bench
  import dsg_pkg::*;
;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, device_capabilities_1, rdat;
  logic sleep_entry, deep_sleep_entry, unit_access_valid, unit_access_fault, irq, go;
  logic [2:0] unit_access_id, go_id;
  logic [NUM_GATED-1:0] unit_clock_enable;
  logic [NUM_RESETS-1:0] unit_reset;
  logic [7:0] port_a_ticks, t0;
  int fails, cmp_count, cyc, nflt;
  dsg_clock_reset_ctrl i_dsg_clock_reset_ctrl (.*);
  dsg_units i_dsg_units (.*);
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (unit_access_fault === 1'b1) nflt <= nflt + 1;
    if (cyc == 2000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Register settles during the access itself, the registered output one edge after it; the two edges are margin
  task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
    tick(2);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic acc(input logic [2:0] i, input int e);
    int n0;
    n0 = nflt;
    go <= 1'b1;
    go_id <= i;
    @(posedge mclk);
    go <= 1'b0;
    tick(3);
    chk(nflt - n0, e);
  endtask
  task automatic mode(input logic s, input logic d, input logic [5:0] e);
    sleep_entry <= s;
    deep_sleep_entry <= d;
    tick(3);
    chk(unit_clock_enable, e);
  endtask
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite, go, sleep_entry, deep_sleep_entry} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    go_id = 3'h0;
    device_capabilities_1 = 32'hffffffff;
    tick(8);
    resetn <= 1'b1;
    tick(3);
    rdc(SRC0_OFFSET, 32'h0);
    rdc(DCG2_OFFSET, 32'h0);
    rdc(RCG2_OFFSET, 32'h0);
    apb(1'b1, 12'h041, 32'hffffffff);
    chk(rerr, 1);
    rdc(SRC0_OFFSET, 32'h0);
    wrr(SRC0_OFFSET, 32'hffffffff);
    rdc(SRC0_OFFSET, 32'h01110048);
    chk(unit_reset, 5'h1f);
    device_capabilities_1 <= 32'h00100008;
    wrr(SRC0_OFFSET, 32'hffffffff);
    rdc(SRC0_OFFSET, 32'h00100008);
    chk(unit_reset, 5'h09);
    wrr(SRC0_OFFSET, 32'h0);
    chk(unit_reset, 5'h00);
    wrr(DCG2_OFFSET, 32'hffffffff);
    rdc(DCG2_OFFSET, 32'h0000201f);
    wrr(RCG2_OFFSET, 32'h00000005);
    chk(unit_clock_enable, 6'h05);
    t0 = port_a_ticks;
    tick(4);
    chk(port_a_ticks - t0, 8'h04);
    acc(3'h1, 1);
    acc(3'h0, 0);
    acc(3'h6, 0);
    wrr(RCG2_OFFSET, 32'h00002000);
    t0 = port_a_ticks;
    tick(4);
    chk(port_a_ticks - t0, 8'h00);
    acc(3'h5, 0);
    rdc(INT_STATUS_OFFSET, 32'h3);
    chk(irq, 0);
    wrr(INT_MASK_OFFSET, 32'h1);
    chk(irq, 1);
    wrr(INT_STATUS_OFFSET, 32'h1);
    chk(irq, 0);
    rdc(INT_STATUS_OFFSET, 32'h2);
    wrr(SCG2_OFFSET, 32'h4);
    wrr(DCG2_OFFSET, 32'h8);
    mode(1'b1, 1'b0, 6'h20);
    wrr(RUN_RCC_OFFSET, 32'h08000000);
    chk(unit_clock_enable, 6'h04);
    mode(1'b1, 1'b1, 6'h08);
    acc(3'h3, 0);
    acc(3'h0, 1);
    mode(1'b0, 1'b0, 6'h20);
    give_verdict();
  end
endmodule // dsg_clock_reset_ctrl_bench
bind dsg_clock_reset_ctrl dsg_clock_reset_ctrl_monitor i_dsg_clock_reset_ctrl_monitor (.*);
`default_nettype wire
